// ==== ccirq_defines.vh ====
// Register offsets, field positions and fetch constants of the command and mask bank
`ifndef CCIRQ_DEFINES_VH
`define CCIRQ_DEFINES_VH
`define CCIRQ_OFF_CMD 8'h00
`define CCIRQ_OFF_PTRL 8'h04
`define CCIRQ_OFF_PTRH 8'h08
`define CCIRQ_OFF_MASK 8'h0C
`define CCIRQ_OFF_SHDL 8'h10
`define CCIRQ_OFF_SHDH 8'h14
`define CCIRQ_OFF_ISTAT 8'h18
`define CCIRQ_OFF_ICLR 8'h1C
`define CCIRQ_OFF_IEN 8'h20
`define CCIRQ_OFF_EVT 8'h24
// Command register fields
`define CCIRQ_B_SETUP 0
`define CCIRQ_B_RUN 1
`define CCIRQ_B_STOP 2
`define CCIRQ_B_GIE 6
`define CCIRQ_B_SUM 7
`define CCIRQ_B_SDONE 8
`define CCIRQ_B_TDONE 9
`define CCIRQ_B_RDONE 10
`define CCIRQ_B_MFLT 11
`define CCIRQ_B_DROP 12
`define CCIRQ_B_OVLG 14
// Event bits 14,12,11,10,9,8 as a mask of the 16-bit word
`define CCIRQ_EVT_BITS 16'h5F00
`define CCIRQ_MASK_BITS 16'h5F00
`define CCIRQ_PTRH_BITS 16'h00FF
`define CCIRQ_PTRL_BITS 16'hFFFE
// Sticky status bits: 0 setup done, 1 run started, 2 summary raised
`define CCIRQ_IS_SDONE 0
`define CCIRQ_IS_RUN 1
`define CCIRQ_IS_SUM 2
`define CCIRQ_IS_W 3
// Setup fetch length in words
`define CCIRQ_FETCH_WORDS 12
// Fetch address step per word, counter step and setup done flag value
`define CCIRQ_FETCH_STEP 24'h00_0002
`define CCIRQ_FETCH_INC 8'h01
`define CCIRQ_SDONE_SET 16'h0100
`define CCIRQ_HTRANS_NONSEQ 2'b10
`endif

// ==== ccirq_regs.v ====
// Command, setup pointer and event mask register bank with AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "ccirq_defines.vh"
// Operation
// - Stop halts all bus and network activity
// - Stop wins over run and setup together
// - Stop set by one or reset
// - Run enable permits frames, clears stop
// - Setup completes before frames with both
// - Run set by one; stop clears
// - Setup request starts block fetch, clears stop
// - Setup request stays set after completion
// - Setup set by one; stop clears
// - Low pointer holds bits 15-0, even
// - Low pointer write copies to shadow
// - High pointer bits 23-16, copies shadow
// - Pointers accessible only while stopped; reset-proof
// - Mask bits block flags from summary
// - Reset clears masks; stop keeps them
// - Mask reserved bits read zero
// - Unmasked flag with global enable raises line
// - Setup done set on fetch end
module ccirq_regs #(
  parameter FETCH_WORDS = `CCIRQ_FETCH_WORDS
) (
  // Clock and reset
  input wire CORE_CLK,
  input wire SYS_RST,
  // AHB-Lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  output wire [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP,
  // Event sources from the controller
  input wire OVLG_EVT,
  input wire DROP_EVT,
  input wire MFLT_EVT,
  input wire RDONE_EVT,
  input wire TDONE_EVT,
  // Setup block memory fetch
  output reg FETCH_REQ,
  output reg [23:0] FETCH_ADDR,
  input wire FETCH_ACK,
  // Controller state
  output wire ACTIVE,
  output wire RUN,
  // Interrupt lines
  output wire IRQ,
  output wire INT_OUT
);
  // Controller states
  localparam ST_HALT = 2'd0;
  localparam ST_INIT = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_IDLE = 2'd3;
  // Last acknowledged word of a setup fetch, cut to the counter width
  localparam integer FETCH_LAST = FETCH_WORDS - 1;
  localparam [31:0] FETCH_LAST_W = FETCH_LAST;

  // Command bits and sequencer
  reg [1:0] state_q;
  reg stop_q;
  reg run_q;
  reg setup_q;
  reg gie_q;
  reg [7:0] fcnt_q;

  // Event flags, masks, pointers and shadows
  reg [15:0] flags_q;
  reg [15:0] mask_q;
  reg [15:0] ptrl_q;
  reg [15:0] ptrh_q;
  reg [15:0] shdl_q;
  reg [15:0] shdh_q;

  // Sticky interrupt status and enable
  reg [`CCIRQ_IS_W-1:0] istat_q;
  reg [`CCIRQ_IS_W-1:0] ien_q;
  reg sum_q;

  // Bus data phase state
  reg wr_q;
  reg [7:0] addr_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // Bus decode
  wire take;
  wire wr;
  wire [15:0] wd;
  wire cmd_wr;
  wire ptrl_wr;
  wire ptrh_wr;
  wire mask_wr;
  wire iclr_wr;
  wire ien_wr;

  // Command decode; stop wins over run and setup
  wire stop_set;
  wire run_set;
  wire setup_set;

  // Fetch and event paths
  reg [15:0] evt_in;
  wire fetch_last;
  wire fetch_done;
  wire [15:0] flag_set;
  wire [15:0] flag_clr;
  wire [15:0] active_flags;
  wire sum_now;
  wire [`CCIRQ_IS_W-1:0] istat_set;
  wire [`CCIRQ_IS_W-1:0] istat_clr;

  // Write-one-to-clear update; a set in the same cycle wins
  function [15:0] w1c;
    input [15:0] cur;
    input [15:0] set;
    input [15:0] clr;
    begin
      w1c = (cur & ~clr) | set;
    end
  endfunction

  // Data-phase write to one register offset
  function wr_hit;
    input wr_en;
    input [7:0] addr;
    input [7:0] offset;
    begin
      wr_hit = wr_en && (addr == offset);
    end
  endfunction

  // Sticky status update, same precedence as the event flags
  function [`CCIRQ_IS_W-1:0] sticky;
    input [`CCIRQ_IS_W-1:0] cur;
    input [`CCIRQ_IS_W-1:0] set;
    input [`CCIRQ_IS_W-1:0] clr;
    begin
      sticky = (cur & ~clr) | set;
    end
  endfunction

  // Register write strobes
  assign take = HSEL && HREADY && HTRANS[1];
  assign wr = wr_q;
  assign wd = HWDATA[15:0];
  assign cmd_wr = wr_hit(wr, addr_q, `CCIRQ_OFF_CMD);
  assign ptrl_wr = wr_hit(wr && stop_q, addr_q, `CCIRQ_OFF_PTRL);
  assign ptrh_wr = wr_hit(wr && stop_q, addr_q, `CCIRQ_OFF_PTRH);
  assign mask_wr = wr_hit(wr, addr_q, `CCIRQ_OFF_MASK);
  assign iclr_wr = wr_hit(wr, addr_q, `CCIRQ_OFF_ICLR);
  assign ien_wr = wr_hit(wr, addr_q, `CCIRQ_OFF_IEN);

  // Command decode
  assign stop_set = cmd_wr && wd[`CCIRQ_B_STOP];
  assign run_set = cmd_wr && wd[`CCIRQ_B_RUN] && !stop_set;
  assign setup_set = cmd_wr && wd[`CCIRQ_B_SETUP] && !stop_set;

  // Fetch completion and interrupt summary
  assign fetch_last = (fcnt_q == FETCH_LAST_W[7:0]);
  assign fetch_done = (state_q == ST_INIT) && FETCH_ACK && fetch_last;
  assign flag_set = (run_q ? evt_in : 16'h0000)
    | (fetch_done ? `CCIRQ_SDONE_SET : 16'h0000);
  assign flag_clr = cmd_wr ? (wd & `CCIRQ_EVT_BITS) : 16'h0000;
  assign active_flags = flags_q & ~mask_q & `CCIRQ_EVT_BITS;
  assign sum_now = |active_flags;
  assign istat_set = {sum_now && !sum_q, run_set, fetch_done};
  assign istat_clr = iclr_wr ? HWDATA[`CCIRQ_IS_W-1:0] : {`CCIRQ_IS_W{1'b0}};

  // Fixed bus response and controller outputs
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;
  assign ACTIVE = !stop_q;
  assign RUN = (state_q == ST_RUN);
  assign INT_OUT = sum_now && gie_q;
  assign IRQ = |(istat_q & ien_q);

  // Controller events placed at their flag positions
  always @* begin
    evt_in = 16'h0000;
    evt_in[`CCIRQ_B_TDONE] = TDONE_EVT;
    evt_in[`CCIRQ_B_RDONE] = RDONE_EVT;
    evt_in[`CCIRQ_B_MFLT] = MFLT_EVT;
    evt_in[`CCIRQ_B_DROP] = DROP_EVT;
    evt_in[`CCIRQ_B_OVLG] = OVLG_EVT;
  end

  // Address phase capture for the following data phase
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take && HWRITE;
      if (take) begin
        addr_q <= HADDR[7:0];
      end
    end
  end

  // Read word for the offset on the address bus
  always @* begin
    rdata_d = 32'h0000_0000;
    case (HADDR[7:0])
      `CCIRQ_OFF_CMD: rdata_d = {16'h0000, flags_q[15:8], sum_now, gie_q, 3'b000,
        stop_q, run_q, setup_q};
      `CCIRQ_OFF_PTRL: rdata_d = stop_q ? {16'h0000, ptrl_q} : 32'h0000_0000;
      `CCIRQ_OFF_PTRH: rdata_d = stop_q ? {16'h0000, ptrh_q} : 32'h0000_0000;
      `CCIRQ_OFF_MASK: rdata_d = {16'h0000, mask_q & `CCIRQ_MASK_BITS};
      `CCIRQ_OFF_SHDL: rdata_d = {16'h0000, shdl_q};
      `CCIRQ_OFF_SHDH: rdata_d = {16'h0000, shdh_q};
      `CCIRQ_OFF_ISTAT: rdata_d = {29'h0000_0000, istat_q};
      `CCIRQ_OFF_IEN: rdata_d = {29'h0000_0000, ien_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Registered read data; a read issued in a write's data phase sees the old value
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !HWRITE) begin
      rdata_q <= rdata_d;
    end
  end

  // Stop: set by one or reset, cleared by run or setup
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      stop_q <= 1'b1;
    end else if (stop_set) begin
      stop_q <= 1'b1;
    end else if (run_set || setup_set) begin
      stop_q <= 1'b0;
    end
  end

  // Run enable: set by one, cleared by stop
  always @(posedge CORE_CLK) begin
    if (SYS_RST || stop_set) begin
      run_q <= 1'b0;
    end else if (run_set) begin
      run_q <= 1'b1;
    end
  end

  // Setup request: stays set once the fetch is over
  always @(posedge CORE_CLK) begin
    if (SYS_RST || stop_set) begin
      setup_q <= 1'b0;
    end else if (setup_set) begin
      setup_q <= 1'b1;
    end
  end

  // Global enable follows every command write
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      gie_q <= 1'b0;
    end else if (cmd_wr) begin
      gie_q <= wd[`CCIRQ_B_GIE];
    end
  end

  // Sequencer; a stop write abandons a fetch in flight
  always @(posedge CORE_CLK) begin
    if (SYS_RST || stop_set) begin
      state_q <= ST_HALT;
    end else begin
      case (state_q)
        ST_HALT, ST_IDLE, ST_RUN: begin
          if (setup_set) begin
            state_q <= ST_INIT;
          end else if (run_set) begin
            state_q <= ST_RUN;
          end
        end
        ST_INIT: begin
          if (fetch_done) begin
            state_q <= (run_q || run_set) ? ST_RUN : ST_IDLE;
          end
        end
        default: state_q <= ST_HALT;
      endcase
    end
  end

  // Setup block fetch: request, address and word count
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      FETCH_REQ <= 1'b0;
      FETCH_ADDR <= 24'h00_0000;
      fcnt_q <= 8'h00;
    end else if (stop_set) begin
      FETCH_REQ <= 1'b0;
    end else if (setup_set && state_q != ST_INIT) begin
      FETCH_REQ <= 1'b1;
      FETCH_ADDR <= {ptrh_q[7:0], ptrl_q};
      fcnt_q <= 8'h00;
    end else if (state_q == ST_INIT && FETCH_ACK) begin
      fcnt_q <= fcnt_q + `CCIRQ_FETCH_INC;
      FETCH_ADDR <= FETCH_ADDR + `CCIRQ_FETCH_STEP;
      if (fetch_done) begin
        FETCH_REQ <= 1'b0;
      end
    end
  end

  // Pointers and shadows keep their contents through reset
  always @(posedge CORE_CLK) begin
    if (ptrl_wr) begin
      ptrl_q <= wd & `CCIRQ_PTRL_BITS;
      shdl_q <= wd & `CCIRQ_PTRL_BITS;
    end
  end

  always @(posedge CORE_CLK) begin
    if (ptrh_wr) begin
      ptrh_q <= wd & `CCIRQ_PTRH_BITS;
      shdh_q <= wd & `CCIRQ_PTRH_BITS;
    end
  end

  // Event flags: set wins over a write-one clear
  always @(posedge CORE_CLK) begin
    if (SYS_RST || stop_set) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= w1c(flags_q, flag_set, flag_clr);
    end
  end

  // Mask register survives stop
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mask_q <= 16'h0000;
    end else if (mask_wr) begin
      mask_q <= wd & `CCIRQ_MASK_BITS;
    end
  end

  // Summary edge detector for the sticky status
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sum_q <= 1'b0;
    end else begin
      sum_q <= sum_now;
    end
  end

  // Interrupt enable register
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ien_q <= {`CCIRQ_IS_W{1'b0}};
    end else if (ien_wr) begin
      ien_q <= HWDATA[`CCIRQ_IS_W-1:0];
    end
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      istat_q <= {`CCIRQ_IS_W{1'b0}};
    end else begin
      istat_q <= sticky(istat_q, istat_set, istat_clr);
    end
  end
endmodule // ccirq_regs
`default_nettype wire

// ==== ccirq_props.sv ====
// Assertion checker for the command and mask register bank
`timescale 1ns/100ps
`default_nettype none
module ccirq_props #(
  parameter FETCH_WORDS = 12
) (
  // Clock, reset and bus
  input wire CORE_CLK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HWDATA,
  // State, fetch and interrupt
  input wire FETCH_REQ,
  input wire FETCH_ACK,
  input wire ACTIVE,
  input wire RUN,
  input wire INT_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  reg wr_q;
  reg [7:0] cnt_q;
  // Command write in data phase; acks counted per fetch
  always @(posedge CORE_CLK) begin
    wr_q <= !SYS_RST && HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == 8'h00;
    cnt_q <= (FETCH_REQ && !SYS_RST) ? cnt_q + {7'h00, FETCH_ACK} : 8'h00;
  end
  property p_stop; wr_q && HWDATA[2] |=> !ACTIVE && !RUN && !FETCH_REQ; endproperty
  a_stop: assert property (p_stop) else $error("stop write left block busy");
  property p_run; wr_q && HWDATA[2:0] == 3'h2 && !FETCH_REQ |=> ACTIVE && RUN; endproperty
  a_run: assert property (p_run) else $error("run write not running");
  property p_setup; wr_q && HWDATA[0] && !HWDATA[2] && !ACTIVE |=> FETCH_REQ && ACTIVE; endproperty
  a_setup: assert property (p_setup) else $error("setup write no fetch");
  property p_order; FETCH_REQ |-> !RUN; endproperty
  a_order: assert property (p_order) else $error("running during fetch");
  property p_zero; wr_q && HWDATA[2:0] == 3'h0 |=> $stable(ACTIVE); endproperty
  a_zero: assert property (p_zero) else $error("zero write moved state");
  property p_rise; $rose(ACTIVE) |-> $past(wr_q && HWDATA[1:0] != 2'h0 && !HWDATA[2]); endproperty
  a_rise: assert property (p_rise) else $error("left stop without command");
  property p_gie; wr_q && !HWDATA[6] |=> !INT_OUT; endproperty
  a_gie: assert property (p_gie) else $error("interrupt without enable");
  property p_len; $fell(FETCH_REQ) && ACTIVE |-> $past(FETCH_ACK) && $past(cnt_q) == FETCH_WORDS - 1; endproperty
  a_len: assert property (p_len) else $error("fetch ended at wrong count");
endmodule // ccirq_props
bind ccirq_regs ccirq_props #(.FETCH_WORDS(FETCH_WORDS)) u_props (.*);
`default_nettype wire

// ==== tb_ccirq_regs.sv ====
// Self-checking bench for the command and mask register bank
`timescale 1ns/100ps
`default_nettype none
module tb_ccirq_regs;
  localparam FW = 3;
  localparam logic [31:0] MC = 32'hFFFF_5FC7;
  logic clk = 0, rst = 1, sel = 0, wr = 0, ack = 0;
  logic [1:0] tr = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [31:0] ad = 0, wd = 0, rd, pl, ph, mk, fl, ex;
  wire [31:0] hrd;
  wire [23:0] fa;
  wire rdy, fr, act, run, irq, io, rsp;
  int fails = 0, checked = 0;
  ccirq_regs #(.FETCH_WORDS(FW)) uut (.CORE_CLK(clk), .SYS_RST(rst), .HSEL(sel), .HADDR(ad),
    .HTRANS(tr), .HWRITE(wr), .HSIZE(3'h2), .HREADY(1'b1), .HWDATA(wd), .HRDATA(hrd),
    .HREADYOUT(rdy), .HRESP(rsp), .OVLG_EVT(ev[4]), .DROP_EVT(ev[3]), .MFLT_EVT(ev[2]),
    .RDONE_EVT(ev[1]), .TDONE_EVT(ev[0]), .FETCH_REQ(fr), .FETCH_ADDR(fa),
    .FETCH_ACK(ack), .ACTIVE(act), .RUN(run), .IRQ(irq), .INT_OUT(io));
  initial forever #2.5 clk = ~clk;
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Entered just after a rising edge; ends on the edge closing the data phase
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    sel <= 1;
    tr <= 2'h2;
    wr <= w;
    ad <= {24'h00_0000, a};
    do @(posedge clk); while (rdy !== 1'b1);
    sel <= 0;
    tr <= 2'h0;
    wd <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrd;
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    bus(0, a, 0);
    cmp(n, e, rd & m);
    cmp("resp", 0, {31'h0000_0000, rsp});
  endtask
  task automatic wrap_up;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    fails++;
    wrap_up;
  end
  initial begin
    void'($urandom(30824));
    repeat (8) @(posedge clk);
    rst <= 0;
    rchk("cmd", 8'h00, 4, MC);
    mk = $urandom & 32'h0000_5F00;
    pl = $urandom & 32'h0000_FFFE;
    ph = $urandom & 32'h0000_00FF;
    bus(1, 8'h04, pl);
    bus(1, 8'h08, ph);
    bus(1, 8'h0C, mk);
    rchk("shdl", 8'h10, pl, ~0);
    rchk("shdh", 8'h14, ph, ~0);
    rchk("mask", 8'h0C, mk, 32'hFFFF_5F00);
    bus(1, 8'h20, 1);
    bus(1, 8'h00, 32'h0000_0043);
    @(negedge clk);
    cmp("fetch", {3'b101, 5'h00, ph[7:0], pl[15:0]}, {fr, run, act, 5'h00, fa});
    repeat (FW) begin @(posedge clk); ack <= 1; @(posedge clk); ack <= 0; end
    fl = 32'h0000_0100;
    for (int k = 0; k <= 5; k++) begin
      ex = ((fl & ~mk) != 0) ? 32'h0000_00C3 | fl : 32'h0000_0043 | fl;
      rchk("cmd", 8'h00, ex, MC);
      cmp("pins", {irq, io, run}, {k == 0, ex[7], 1'b1});
      if (k == 0) bus(1, 8'h1C, 1);
      if (k < 5) begin
        ev <= 5'h01 << k;
        fl = fl | (32'h0000_0200 << (k == 4 ? 5 : k));
        @(posedge clk);
        ev <= 5'h00;
      end
    end
    bus(1, 8'h04, ~pl);
    rchk("ptrl", 8'h04, 0, ~0);
    bus(1, 8'h00, 0);
    bus(1, 8'h00, 7);
    rchk("cmd", 8'h00, 4, MC);
    bus(1, 8'h00, 2);
    rchk("cmd", 8'h00, 2, MC);
    bus(1, 8'h00, 4);
    rchk("mask", 8'h0C, mk, 32'hFFFF_5F00);
    rst <= 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    rchk("ptrl", 8'h04, pl, ~0);
    rchk("mask", 8'h0C, 0, 32'hFFFF_5F00);
    wrap_up;
  end
endmodule // tb_ccirq_regs
`default_nettype wire
